/* File: hdl/sflash_read_seq.sv */
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`include "sflash_defs.svh"

module sflash_read_seq (
  input  wire logic                  clock_in,        // 100 MHz system clock
  input  wire logic                  rst_in,          // Synchronous reset, high
  input  wire logic                  sck_in,          // Serial clock from host
  input  wire logic                  cs_n_in,         // Chip select, active low
  input  wire logic                  si_in,           // Serial data in
  input  wire logic                  page_binary_in,  // 1 = 512-byte pages
  input  wire logic [7:0]            fetch_data_in,   // Byte, cycle after request
  output logic                       so_out,          // Serial data out
  output logic                       so_oe_out,       // Serial out drive enable
  output sflash_pkg::fetch_req_t     fetch_out,       // Byte fetch address
  output logic                       fetch_valid_out  // Fetch request pulse
);
  import sflash_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] sck_s_q, sck_s_d;
  logic [2:0] cs_s_q, cs_s_d;
  logic [2:0] si_s_q, si_s_d;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_high;
  logic       si_bit;

  always_comb begin
    sck_s_d = {sck_s_q[1:0], sck_in};
    cs_s_d  = {cs_s_q[1:0], cs_n_in};
    si_s_d  = {si_s_q[1:0], si_in};
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sck_s_q <= 3'h0;
      cs_s_q  <= 3'h7;
      si_s_q  <= 3'h0;
    end else begin
      sck_s_q <= sck_s_d;
      cs_s_q  <= cs_s_d;
      si_s_q  <= si_s_d;
    end
  end

  // An edge counts once stages two and three disagree; data taken alongside
  assign sck_rise = sck_s_q[1] & ~sck_s_q[2];
  assign sck_fall = ~sck_s_q[1] & sck_s_q[2];
  assign cs_high  = cs_s_q[1] & cs_s_q[2];
  assign si_bit   = si_s_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  function automatic cmd_cfg_t decode_opcode(input logic [7:0] opc);
    cmd_cfg_t c;
    c = '{known: 1'b1, target: TGT_ARRAY, dummy_bytes: `DUMMY_NONE};
    case (opc)
      `OPC_ARRAY_FAST:   c.dummy_bytes = `DUMMY_ONE;
      `OPC_ARRAY_SLOW:   c.dummy_bytes = `DUMMY_NONE;
      `OPC_ARRAY_LOWPWR: c.dummy_bytes = `DUMMY_NONE;
      `OPC_PAGE_READ: begin
        c.target      = TGT_PAGE;
        c.dummy_bytes = `DUMMY_PAGE;
      end
      `OPC_BUF1_FAST: begin
        c.target      = TGT_BUF1;
        c.dummy_bytes = `DUMMY_ONE;
      end
      `OPC_BUF1_SLOW:    c.target = TGT_BUF1;
      `OPC_BUF2_FAST: begin
        c.target      = TGT_BUF2;
        c.dummy_bytes = `DUMMY_ONE;
      end
      `OPC_BUF2_SLOW:    c.target = TGT_BUF2;
      default:           c.known  = 1'b0;
    endcase
    return c;
  endfunction

  // Split the three address bytes by page-size setting and target
  function automatic fetch_req_t split_address(input logic [23:0] a, input logic binary,
                                               input read_target_t tgt);
    fetch_req_t r;
    r = '0;
    r.from_buffer = tgt[1];
    r.buffer_two  = (tgt == TGT_BUF2);
    if (tgt[1]) begin
      // Leading ignored bits simply never reach the offset
      if (binary) begin
        r.byte_offset_field = {1'b0, a[8:0]};
      end else begin
        r.byte_offset_field = a[9:0];
      end
    end else if (binary) begin
      r.page_number_field = a[`NARROW_PAGE_MSB:`NARROW_PAGE_LSB];
      r.byte_offset_field = {1'b0, a[8:0]};
    end else begin
      r.page_number_field = a[`WIDE_PAGE_MSB:`WIDE_PAGE_LSB];
      r.byte_offset_field = a[9:0];
    end
    return r;
  endfunction

  // Next byte address; offsets beyond the last byte also wrap
  function automatic fetch_req_t next_address(input fetch_req_t cur, input logic binary,
                                              input read_target_t tgt);
    fetch_req_t  r;
    logic [9:0]  last;
    r    = cur;
    last = binary ? `LAST_OFFSET_NARROW : `LAST_OFFSET_WIDE;
    if (cur.byte_offset_field >= last) begin
      r.byte_offset_field = 10'h000;
      if (tgt == TGT_ARRAY) begin
        // Page counter rolls from the last page to zero by itself
        r.page_number_field = cur.page_number_field + 12'h001;
      end
    end else begin
      r.byte_offset_field = cur.byte_offset_field + 10'h001;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  seq_state_t  state_q, state_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [23:0] shift_in_q, shift_in_d;
  cmd_cfg_t    cfg_q, cfg_d;
  fetch_req_t  addr_q, addr_d;
  logic [7:0]  out_q, out_d;
  logic [2:0]  bit_q, bit_d;
  logic        so_q, so_d;
  logic        oe_q, oe_d;
  logic        fetch_v_q, fetch_v_d;
  logic        pend_q, pend_d;
  logic [7:0]  pre_q, pre_d;

  always_comb begin
    logic [23:0] shifted;
    fetch_req_t  start;
    fetch_req_t  adv;
    shifted    = {shift_in_q[22:0], si_bit};
    start      = split_address(shifted, page_binary_in, cfg_q.target);
    adv        = next_address(addr_q, page_binary_in, cfg_q.target);
    state_d    = state_q;
    cnt_d      = cnt_q;
    shift_in_d = shift_in_q;
    cfg_d      = cfg_q;
    addr_d     = addr_q;
    out_d      = out_q;
    bit_d      = bit_q;
    so_d       = so_q;
    oe_d       = oe_q;
    fetch_v_d  = 1'b0;
    pend_d     = fetch_v_q;
    pre_d      = pend_q ? fetch_data_in : pre_q;

    if (cs_high) begin
      // Frame over: drop drive at once and rearm for an opcode
      state_d = ST_OPCODE;
      cnt_d   = 6'h00;
      oe_d    = 1'b0;
      so_d    = 1'b0;
      bit_d   = 3'h0;
    end else begin
      case (state_q)
        ST_OPCODE: begin
          if (sck_rise) begin
            shift_in_d = shifted;
            cnt_d      = cnt_q + 6'h01;
            if (cnt_q == `OPCODE_LAST_BIT) begin
              cfg_d   = decode_opcode(shifted[7:0]);
              state_d = cfg_d.known ? ST_ADDR : ST_IGNORE;
              cnt_d   = 6'h00;
            end
          end
        end
        ST_ADDR: begin
          if (sck_rise) begin
            shift_in_d = shifted;
            cnt_d      = cnt_q + 6'h01;
            if (cnt_q == `ADDR_LAST_BIT) begin
              addr_d    = start;
              fetch_v_d = 1'b1;
              cnt_d     = 6'h00;
              bit_d     = 3'h0;
              state_d   = (cfg_q.dummy_bytes == `DUMMY_NONE) ? ST_DATA : ST_DUMMY;
            end
          end
        end
        ST_DUMMY: begin
          if (sck_rise) begin
            cnt_d = cnt_q + 6'h01;
            if (cnt_q == {cfg_q.dummy_bytes - 3'h1, 3'h7}) begin
              cnt_d   = 6'h00;
              state_d = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          // One bit per falling edge; byte boundary fetches the next one
          if (sck_fall) begin
            oe_d  = 1'b1;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h0) begin
              so_d      = pre_q[7];
              out_d     = {pre_q[6:0], 1'b0};
              addr_d    = adv;
              fetch_v_d = 1'b1;
            end else begin
              so_d  = out_q[7];
              out_d = {out_q[6:0], 1'b0};
            end
          end
        end
        ST_IGNORE: begin
          // Unknown opcode: sit out the frame with output released
          oe_d = 1'b0;
        end
        default: begin
          state_d = ST_OPCODE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q    <= ST_OPCODE;
      cnt_q      <= 6'h00;
      shift_in_q <= 24'h000000;
      cfg_q      <= '0;
      addr_q     <= '0;
      out_q      <= 8'h00;
      bit_q      <= 3'h0;
      so_q       <= 1'b0;
      oe_q       <= 1'b0;
      fetch_v_q  <= 1'b0;
      pend_q     <= 1'b0;
      pre_q      <= 8'h00;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      shift_in_q <= shift_in_d;
      cfg_q      <= cfg_d;
      addr_q     <= addr_d;
      out_q      <= out_d;
      bit_q      <= bit_d;
      so_q       <= so_d;
      oe_q       <= oe_d;
      fetch_v_q  <= fetch_v_d;
      pend_q     <= pend_d;
      pre_q      <= pre_d;
    end
  end

  // Read-only fetch port: no path exists to write either buffer
  assign fetch_out       = addr_q;
  assign fetch_valid_out = fetch_v_q;
  assign so_out          = so_q;
  assign so_oe_out       = oe_q;

endmodule

/* File: inc/sflash_defs.svh */
`ifndef SFLASH_DEFS_SVH
`define SFLASH_DEFS_SVH

// Read opcodes
`define OPC_ARRAY_FAST   8'h0B
`define OPC_ARRAY_SLOW   8'h03
`define OPC_ARRAY_LOWPWR 8'h01
`define OPC_PAGE_READ    8'hD2
`define OPC_BUF1_FAST    8'hD4
`define OPC_BUF1_SLOW    8'hD1
`define OPC_BUF2_FAST    8'hD6
`define OPC_BUF2_SLOW    8'hD3

// Dummy byte counts per command
`define DUMMY_NONE       3'h0
`define DUMMY_ONE        3'h1
`define DUMMY_PAGE       3'h4

// Frame phase lengths in serial clock rising edges, minus one
`define OPCODE_LAST_BIT  6'h07
`define ADDR_LAST_BIT    6'h17

// Last byte offset of a page or buffer
`define LAST_OFFSET_WIDE   10'h20F
`define LAST_OFFSET_NARROW 10'h1FF

// Address field positions within the three address bytes
`define WIDE_PAGE_MSB    21
`define WIDE_PAGE_LSB    10
`define NARROW_PAGE_MSB  20
`define NARROW_PAGE_LSB  9

`endif

/* File: inc/sflash_pkg.sv */
package sflash_pkg;

  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR   = 3'b001,
    ST_DUMMY  = 3'b010,
    ST_DATA   = 3'b011,
    ST_IGNORE = 3'b100
  } seq_state_t;

  typedef enum logic [1:0] {
    TGT_ARRAY = 2'b00,
    TGT_PAGE  = 2'b01,
    TGT_BUF1  = 2'b10,
    TGT_BUF2  = 2'b11
  } read_target_t;

  typedef struct packed {
    logic         known;
    read_target_t target;
    logic [2:0]   dummy_bytes;
  } cmd_cfg_t;

  typedef struct packed {
    logic        from_buffer;
    logic        buffer_two;
    logic [11:0] page_number_field;
    logic [9:0]  byte_offset_field;
  } fetch_req_t;

endpackage

/* File: verif/sflash_read_seq_assertions.sv */
`timescale 1ns/10ps
module sflash_read_seq_assertions (
  input wire logic                   clock_in,        // System clock
  input wire logic                   rst_in,          // Sync reset
  input wire logic                   sck_in,          // Serial clock
  input wire logic                   cs_n_in,         // Select, low
  input wire logic                   page_binary_in,  // 512 layout
  input wire logic                   so_out,          // Serial out
  input wire logic                   so_oe_out,       // Out enable
  input wire sflash_pkg::fetch_req_t fetch_out,       // Fetch address
  input wire logic                   fetch_valid_out  // Fetch strobe
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_oe_release: assert property ($rose(cs_n_in) |-> ##[1:5] !so_oe_out)
    else $error("output still driven after deselect");
  a_so_quiet: assert property (!so_oe_out |-> !so_out)
    else $error("serial out not low while released");
  a_fetch_pulse: assert property (fetch_valid_out |=> !fetch_valid_out)
    else $error("fetch strobe longer than one cycle");
  // Synchroniser delay lets the low clock still show two cycles back
  a_so_on_fall: assert property (so_oe_out && $past(so_oe_out) && $changed(so_out) |-> !$past(sck_in, 2))
    else $error("serial out changed outside low clock phase");
  a_oe_start: assert property ($rose(so_oe_out) |-> !$past(sck_in, 2) && !$past(cs_n_in, 4))
    else $error("output enabled without falling clock in frame");
  a_fetch_in_frame: assert property (fetch_valid_out |-> !$past(cs_n_in, 3))
    else $error("fetch outside a selected frame");
  a_buf_page_zero: assert property (fetch_valid_out && fetch_out.from_buffer
    |-> fetch_out.page_number_field == 12'h000)
    else $error("buffer fetch carries a page number");
  a_bin_offset: assert property (fetch_valid_out && page_binary_in |-> !fetch_out.byte_offset_field[9])
    else $error("offset above nine bits in binary layout");
endmodule
bind sflash_read_seq sflash_read_seq_assertions u_sflash_read_seq_assertions (
  .clock_in(clock_in), .rst_in(rst_in), .sck_in(sck_in), .cs_n_in(cs_n_in), .page_binary_in(page_binary_in),
  .so_out(so_out), .so_oe_out(so_oe_out), .fetch_out(fetch_out), .fetch_valid_out(fetch_valid_out));

/* File: verif/spi_host_model.sv */
`timescale 1ns/10ps
module spi_host_model (
  input  wire logic clock_in,  // Bench clock
  input  wire logic so_in,     // Device serial out
  output logic      sck_out,   // Serial clock, idles low
  output logic      cs_n_out,  // Select, low
  output logic      si_out     // Serial data to device
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic xfer(input logic [7:0] opc, input logic [23:0] adr, input int ndum, input int nbits,
                      output logic [7:0] rx[$]);
    int hdr;
    logic [7:0] sh;
    hdr = 32 + 8 * ndum;
    rx = {};
    cs_n_out = 1'b0;
    hc(4);
    for (int i = 0; i < hdr + nbits; i++) begin
      sck_out = 1'b0;
      si_out = (i < 8) ? opc[7 - i] : (i < 32) ? adr[31 - i] : i[0];
      hc(6);
      if (i >= hdr) begin
        sh = {sh[6:0], so_in};
        if ((i - hdr) % 8 == 7) rx.push_back(sh);
      end
      sck_out = 1'b1;
      // Alternating 6/7 high phase gives a 125 ns average period, inside every read limit
      hc(6 + i % 2);
    end
    sck_out = 1'b0;
    hc(6);
    cs_n_out = 1'b1;
    si_out = ~si_out;
    hc(4);
  endtask
endmodule

/* File: verif/sflash_read_seq_tb.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module sflash_read_seq_tb;
  import sflash_pkg::*;
  logic       clock_in;
  logic       rst_in;
  logic       sck;
  logic       cs_n;
  logic       si;
  logic       page_binary_in;
  logic [7:0] fetch_data_in;
  logic       so_out;
  logic       so_oe_out;
  logic       so_line;
  fetch_req_t fetch_out;
  logic       fetch_valid_out;
  logic [7:0] rx[$];
  int         miscompares = 0;
  int         cmp_count = 0;
  sflash_read_seq u_sflash_read_seq (
    .clock_in(clock_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .page_binary_in(page_binary_in), .fetch_data_in(fetch_data_in), .so_out(so_out),
    .so_oe_out(so_oe_out), .fetch_out(fetch_out), .fetch_valid_out(fetch_valid_out));
  // Released line floats high through a pull-up, so stale data cannot pass
  assign so_line = so_oe_out ? so_out : 1'b1;
  spi_host_model u_spi_host_model (
    .clock_in(clock_in), .so_in(so_line), .sck_out(sck), .cs_n_out(cs_n), .si_out(si));
  function automatic logic [7:0] mem_byte(logic fb, logic b2, logic [11:0] pg, logic [9:0] off);
    return off[7:0] ^ {pg[5:0], off[9:8]} ^ {fb, b2, pg[11:6]};
  endfunction
  // Storage answers one cycle after each fetch strobe
  always @(posedge clock_in) begin
    if (rst_in)
      fetch_data_in <= 8'h00;
    else if (fetch_valid_out === 1'b1)
      fetch_data_in <= mem_byte(fetch_out.from_buffer, fetch_out.buffer_two,
                                fetch_out.page_number_field, fetch_out.byte_offset_field);
  end
  task automatic run_read(input logic [7:0] opc, input logic [23:0] adr, input int ndum, input int nb,
                          input read_target_t kind);
    logic [11:0] pg;
    logic [9:0] off;
    logic [9:0] last;
    logic fb;
    fb = (kind == TGT_BUF1) || (kind == TGT_BUF2);
    last = page_binary_in ? 10'h1FF : 10'h20F;
    off = page_binary_in ? {1'b0, adr[8:0]} : adr[9:0];
    pg = fb ? 12'h000 : page_binary_in ? adr[20:9] : adr[21:10];
    u_spi_host_model.xfer(opc, adr, ndum, nb * 8, rx);
    for (int i = 0; i < nb; i++) begin
      `CHK(rx[i], mem_byte(fb, kind == TGT_BUF2, pg, off))
      if (off >= last) begin
        off = 10'h000;
        if (kind == TGT_ARRAY) pg = pg + 12'h001;
      end else
        off = off + 10'h001;
    end
  endtask
  task automatic t_array_cmds();
    logic [7:0] opcs[3] = '{8'h0B, 8'h03, 8'h01};
    int dum[3] = '{1, 0, 0};
    page_binary_in = 1'b0;
    for (int i = 0; i < 3; i++)
      run_read(opcs[i], {2'h0, 12'h005, 10'h20E}, dum[i], 3, TGT_ARRAY);
  endtask
  task automatic t_array_wrap();
    page_binary_in = 1'b1;
    run_read(8'h0B, {3'h0, 12'hFFF, 9'h1FE}, 1, 3, TGT_ARRAY);
    page_binary_in = 1'b0;
    run_read(8'h03, {2'h0, 12'hFFF, 10'h20F}, 0, 2, TGT_ARRAY);
  endtask
  task automatic t_page_read();
    page_binary_in = 1'b0;
    run_read(8'hD2, {2'h0, 12'h007, 10'h20E}, 4, 3, TGT_PAGE);
    page_binary_in = 1'b1;
    run_read(8'hD2, {3'h0, 12'h008, 9'h1FF}, 4, 2, TGT_PAGE);
  endtask
  task automatic t_buffers();
    logic [7:0] opcs[4] = '{8'hD4, 8'hD1, 8'hD6, 8'hD3};
    read_target_t tgt;
    for (int i = 0; i < 4; i++) begin
      tgt = (i < 2) ? TGT_BUF1 : TGT_BUF2;
      page_binary_in = 1'b0;
      run_read(opcs[i], {14'h3FFF, 10'h20E}, 1 - i % 2, 3, tgt);
      page_binary_in = 1'b1;
      run_read(opcs[i], {15'h7FFF, 9'h1FF}, 1 - i % 2, 2, tgt);
    end
  endtask
  task automatic t_abort();
    page_binary_in = 1'b0;
    u_spi_host_model.xfer(8'h0B, 24'h000000, 1, 12, rx);
    `CHK(so_oe_out, 1'b0)
    `CHK(rx[0], mem_byte(1'b0, 1'b0, 12'h000, 10'h000))
    u_spi_host_model.xfer(8'hAA, 24'h000000, 0, 16, rx);
    `CHK({rx[0], rx[1]}, 16'hFFFF)
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  initial begin
    rst_in = 1'b1;
    page_binary_in = 1'b0;
    repeat (3) @(posedge clock_in);
    #1 rst_in = 1'b0;
    repeat (4) @(posedge clock_in);
    #1;
    t_array_cmds();
    t_array_wrap();
    t_page_read();
    t_buffers();
    t_abort();
    print_verdict();
  end
  // About 13k cycles expected; three times that is a hang
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end
endmodule
